// ### design/wsevt_pkg.sv
// Shared constants and types for the sequencer event-trigger front end.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package wsevt_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int STEP_NS = 3300;
   localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int UNIT_NS = 61440;
   localparam int UNIT_CYC = (UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 28;
   // ----------------------------------------------------------------
   // Register map (word indices, byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam logic [13:0] IDX_STATUS = 14'h0017;
   localparam logic [13:0] IDX_CLAMP_RISE = 14'h0066;
   localparam logic [13:0] IDX_CLAMP_FALL = 14'h0067;
   localparam logic [13:0] IDX_PIN_RISE = 14'h0068;
   localparam logic [13:0] IDX_PIN_FALL = 14'h0069;
   localparam logic [13:0] IDX_JACK_RISE = 14'h006A;
   localparam logic [13:0] IDX_JACK_FALL = 14'h006B;
   localparam logic [13:0] IDX_DET_RISE = 14'h006E;
   localparam logic [13:0] IDX_DET_FALL = 14'h006F;
   localparam logic [13:0] IDX_CTRL = 14'h0070;
   localparam logic [5:0] MEM_PAGE = 6'h10;
   localparam int NSRC = 8;
   localparam logic [13:0] IDX_TRIG [NSRC] = '{IDX_CLAMP_RISE, IDX_CLAMP_FALL,
      IDX_PIN_RISE, IDX_PIN_FALL, IDX_JACK_RISE, IDX_JACK_FALL, IDX_DET_RISE, IDX_DET_FALL};
   // ----------------------------------------------------------------
   // Field values
   // ----------------------------------------------------------------
   localparam logic [8:0] IDX_ABORT = 9'h1FF;
   localparam logic [8:0] IDX_RST = 9'h1FF;
   localparam logic [8:0] LAST_RST = 9'h000;
   localparam logic [7:0] IDX_TOP = 8'hFF;
   localparam logic [3:0] DLY_MIN = 4'h0;
   localparam logic [3:0] DLY_END = 4'hF;
   localparam int BUSY_BIT = 9;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
   // One sequencer step word as stored in memory
   typedef struct packed {
      logic [2:0] width;
      logic [12:0] addr;
      logic [3:0] delay;
      logic [3:0] lsb;
      logic [7:0] data;
   } wsevt_step_t;
   // Control register, bit 2 downward
   typedef struct packed {
      logic clamp_pin;
      logic clamp_jack;
      logic sd_en;
   } wsevt_ctl_t;
   localparam wsevt_ctl_t CTL_RST = 3'h0;
endpackage

// ### design/wsevt_edge.sv
// Level synchroniser with rise and fall pulse detection.
// Assumes level_i is asynchronous when SYNC is set, same clock otherwise.
`timescale 1ns/1ps
module wsevt_edge #(
   parameter bit SYNC = 1'b1
) (
   input wire logic clk_i,   // System clock
   input wire logic rst_i,   // Async reset, high
   input wire logic level_i, // Source level
   output logic level_o,     // Level in clock domain
   output logic rise_o,      // One-cycle rise pulse
   output logic fall_o       // One-cycle fall pulse
);
   logic prev_q;
   logic prime_q;
   generate
      if (SYNC) begin : g_sync
         logic s1_q;
         logic s2_q;
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
            end else begin
               s1_q <= level_i;
               s2_q <= s1_q;
            end
         end
         assign level_o = s2_q;
      end else begin : g_direct
         assign level_o = level_i;
      end
   endgenerate
   // Primed flag keeps a level present at reset release from firing when SYNC is clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
         prime_q <= 1'b0;
      end else begin
         prev_q <= level_o;
         prime_q <= 1'b1;
      end
   end
   assign rise_o = prime_q & level_o & ~prev_q;
   assign fall_o = prime_q & ~level_o & prev_q;
endmodule // wsevt_edge

// ### design/wsevt_mem.sv
// Sequencer step memory, 256 words, one write and two read ports.
// Assumes callers keep indices within 0 to 255.
`timescale 1ns/1ps
module wsevt_mem (
   input wire logic clk_i,         // System clock
   input wire logic we_i,          // Write enable
   input wire logic [7:0] waddr_i, // Write index
   input wire logic [31:0] wdata_i, // Write data
   input wire logic [31:0] wmask_i, // Bit write mask
   input wire logic [7:0] ra_i,    // Sequencer read index
   output logic [31:0] rd_a_o,     // Sequencer read data
   input wire logic [7:0] rb_i,    // Bus read index
   output logic [31:0] rd_b_o      // Bus read data
);
   logic [31:0] mem [256];
   // No reset: contents persist across resets, start undefined
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= (mem[waddr_i] & ~wmask_i) | (wdata_i & wmask_i);
      end
   end
   assign rd_a_o = mem[ra_i];
   assign rd_b_o = mem[rb_i];
endmodule // wsevt_mem

// ### design/wsevt_top.sv
// Event-trigger front end of a register-write sequencer with AXI4-Lite
// registers. Assumes all pins asynchronous and one 125 MHz clock.
// Functional notes
// - Pin trigger follows general pin five level
// - Clamp from jack/pin; clamp edges trigger too
// - Rise, fall or both edges launch sequences
// - Each edge starts at its own index
// - Index 1FFh aborts instead of executing
// - All start indices reset to 1FFh
// - Detect enable triggers on both detect edges
// - Per-edge detect gating only by 1FFh index
// - Memory undefined at power-up, software writable
// - Memory survives all resets
// - Read-only busy flag at status bit 9
// - Status reports last accessed index, resets 0
// - Sequencer status feeds interrupt logic
// - Sequencer status drives a pin
// - Queue triggers; flag when queue drains
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module wsevt_top #(
   parameter int UNIT_CYC_P = wsevt_pkg::UNIT_CYC
) (
   input wire logic clk_i,                       // System clock
   input wire logic rst_i,                       // Async reset, high
   input wire logic [wsevt_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid,               // Write address valid
   output logic s_axi_awready,                   // Write address ready
   input wire logic [31:0] s_axi_wdata,          // Write data
   input wire logic [3:0] s_axi_wstrb,           // Write strobes
   input wire logic s_axi_wvalid,                // Write data valid
   output logic s_axi_wready,                    // Write data ready
   output logic [1:0] s_axi_bresp,               // Write response
   output logic s_axi_bvalid,                    // Write response valid
   input wire logic s_axi_bready,                // Write response ready
   input wire logic [wsevt_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid,               // Read address valid
   output logic s_axi_arready,                   // Read address ready
   output logic [31:0] s_axi_rdata,              // Read data
   output logic [1:0] s_axi_rresp,               // Read response
   output logic s_axi_rvalid,                    // Read data valid
   input wire logic s_axi_rready,                // Read data ready
   input wire logic accessory_detect_i,          // Jack detect level
   input wire logic general_pin_five_i,          // Pin five level
   input wire logic detect_i,                    // Signal-detect output
   output logic clamp_o,                         // Mic detect clamp
   output logic seq_busy_o,                      // Busy, to pin and irq
   output logic seq_done_o,                      // Queue drained pulse
   output logic cmd_valid_o,                     // Step issued pulse
   output wsevt_pkg::wsevt_step_t cmd_o          // Issued step
);
   import wsevt_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_EXEC, S_WAIT} wsevt_st_t;

   logic jack_s, pin_s, det_s, clamp_s;
   logic jack_r, jack_f, pin_r, pin_f, det_r, det_f, clamp_r, clamp_f;
   logic [NSRC-1:0] trig, clr, pend_q, pend_d;
   logic [8:0] idx_q [NSRC];
   logic [8:0] sel_idx, cur_q, cur_d, last_q, last_d;
   logic [2:0] sel_n;
   wsevt_ctl_t ctl_q;
   wsevt_st_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d, load;
   logic end_q;
   wsevt_step_t step;
   logic [31:0] mem_b, wmask;
   logic aw_got_q, w_got_q, do_wr, bvalid_d, rvalid_d, aw_got_d, w_got_d;
   logic [13:0] aw_idx_q, ar_idx;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic mem_we;
   logic [31:0] rd_val;
   logic rd_hit;

   // ----------------------------------------------------------------
   // Trigger sources
   // ----------------------------------------------------------------
   wsevt_edge #(.SYNC(1'b1)) u_jack (
      .clk_i(clk_i), .rst_i(rst_i), .level_i(accessory_detect_i),
      .level_o(jack_s), .rise_o(jack_r), .fall_o(jack_f));
   wsevt_edge #(.SYNC(1'b1)) u_pin (
      .clk_i(clk_i), .rst_i(rst_i), .level_i(general_pin_five_i),
      .level_o(pin_s), .rise_o(pin_r), .fall_o(pin_f));
   wsevt_edge #(.SYNC(1'b1)) u_det (
      .clk_i(clk_i), .rst_i(rst_i), .level_i(detect_i),
      .level_o(det_s), .rise_o(det_r), .fall_o(det_f));
   wsevt_edge #(.SYNC(1'b0)) u_clamp (
      .clk_i(clk_i), .rst_i(rst_i), .level_i(clamp_o),
      .level_o(clamp_s), .rise_o(clamp_r), .fall_o(clamp_f));

   // Clamp driven by jack, pin or both as configured
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clamp_o <= 1'b0;
      end else begin
         clamp_o <= (ctl_q.clamp_jack & jack_s) | (ctl_q.clamp_pin & pin_s);
      end
   end

   // Detect edges share one enable; per-edge gating is via index 1FFh
   assign trig = {det_f & ctl_q.sd_en, det_r & ctl_q.sd_en,
                  jack_f, jack_r, pin_f, pin_r, clamp_f, clamp_r};

   // ----------------------------------------------------------------
   // Pending queue and selection
   // ----------------------------------------------------------------
   always_comb begin
      sel_n = 3'd0;
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (pend_q[k]) begin
            sel_n = 3'(k);
         end
      end
      sel_idx = idx_q[sel_n];
   end

   // A new edge on a source being served stays pending
   assign pend_d = (pend_q & ~clr) | trig;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_q <= '0;
      end else begin
         pend_q <= pend_d;
      end
   end

   // ----------------------------------------------------------------
   // Sequence walker
   // ----------------------------------------------------------------
   logic [31:0] mem_a_word;
   assign step = wsevt_step_t'(mem_a_word);

   always_comb begin
      if (step.delay == DLY_MIN || step.delay == DLY_END) begin
         load = CNT_W'(STEP_CYC);
      end else begin
         load = CNT_W'(UNIT_CYC_P) * ((CNT_W'(1) << step.delay) - CNT_W'(1));
      end
   end

   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      last_d = last_q;
      cnt_d = cnt_q;
      clr = '0;
      case (st_q)
         S_IDLE: begin
            if (|pend_q) begin
               clr[sel_n] = 1'b1;
               if (sel_idx != IDX_ABORT) begin
                  cur_d = sel_idx;
                  st_d = S_EXEC;
               end
            end
         end
         S_EXEC: begin
            last_d = cur_q;
            cnt_d = load - CNT_W'(2);
            st_d = S_WAIT;
         end
         S_WAIT: begin
            if (cnt_q == '0) begin
               if (end_q || cur_q[7:0] == IDX_TOP) begin
                  st_d = S_IDLE;
               end else begin
                  cur_d = cur_q + 9'd1;
                  st_d = S_EXEC;
               end
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= S_IDLE;
         cur_q <= LAST_RST;
         last_q <= LAST_RST;
         cnt_q <= '0;
         end_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cur_q <= cur_d;
         last_q <= last_d;
         cnt_q <= cnt_d;
         if (st_q == S_EXEC) begin
            end_q <= (step.delay == DLY_END);
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_valid_o <= 1'b0;
         cmd_o <= '0;
      end else begin
         cmd_valid_o <= (st_q == S_EXEC);
         if (st_q == S_EXEC) begin
            cmd_o <= step;
         end
      end
   end

   // Busy covers queued, running and aborted sequences
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         seq_busy_o <= 1'b0;
         seq_done_o <= 1'b0;
      end else begin
         seq_busy_o <= (st_d != S_IDLE) || (|pend_d);
         seq_done_o <= (st_d == S_IDLE) && (pend_d == '0) &&
                       ((st_q != S_IDLE) || (|pend_q));
      end
   end

   // ----------------------------------------------------------------
   // Step memory
   // ----------------------------------------------------------------
   assign mem_we = do_wr && (aw_idx_q[13:8] == MEM_PAGE);
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign ar_idx = s_axi_araddr[15:2];

   wsevt_mem u_mem (
      .clk_i(clk_i),
      .we_i(mem_we),
      .waddr_i(aw_idx_q[7:0]),
      .wdata_i(wdata_q),
      .wmask_i(wmask),
      .ra_i(cur_q[7:0]),
      .rd_a_o(mem_a_word),
      .rb_i(ar_idx[7:0]),
      .rd_b_o(mem_b)
   );

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
   assign aw_got_d = (aw_got_q | (s_axi_awready & s_axi_awvalid)) & ~do_wr;
   assign w_got_d = (w_got_q | (s_axi_wready & s_axi_wvalid)) & ~do_wr;
   assign bvalid_d = s_axi_bvalid ? !s_axi_bready : do_wr;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_idx_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
      end else begin
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         if (s_axi_awready && s_axi_awvalid) begin
            aw_idx_q <= s_axi_awaddr[15:2];
         end
         if (s_axi_wready && s_axi_wvalid) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         s_axi_awready <= !aw_got_d && !bvalid_d;
         s_axi_wready <= !w_got_d && !bvalid_d;
         s_axi_bvalid <= bvalid_d;
         if (do_wr) begin
            s_axi_bresp <= (wr_hit(aw_idx_q) || aw_idx_q == IDX_STATUS) ? RESP_OK : RESP_ERR;
         end
      end
   end

   function automatic logic wr_hit(input logic [13:0] a);
      wr_hit = (a[13:8] == MEM_PAGE) || (a == IDX_CTRL);
      for (int k = 0; k < NSRC; k++) begin
         if (a == IDX_TRIG[k]) begin
            wr_hit = 1'b1;
         end
      end
   endfunction

   // Start-index fields and control bits
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int k = 0; k < NSRC; k++) begin
            idx_q[k] <= IDX_RST;
         end
         ctl_q <= CTL_RST;
      end else if (do_wr) begin
         for (int k = 0; k < NSRC; k++) begin
            if (aw_idx_q == IDX_TRIG[k]) begin
               idx_q[k] <= (idx_q[k] & ~wmask[8:0]) | (wdata_q[8:0] & wmask[8:0]);
            end
         end
         if (aw_idx_q == IDX_CTRL && wstrb_q[0]) begin
            ctl_q <= wdata_q[2:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      if (ar_idx[13:8] == MEM_PAGE) begin
         rd_val = mem_b;
      end else if (ar_idx == IDX_STATUS) begin
         rd_val[BUSY_BIT] = seq_busy_o;
         rd_val[8:0] = last_q;
      end else if (ar_idx == IDX_CTRL) begin
         rd_val[2:0] = ctl_q;
      end else begin
         rd_hit = 1'b0;
         for (int k = 0; k < NSRC; k++) begin
            if (ar_idx == IDX_TRIG[k]) begin
               rd_val[8:0] = idx_q[k];
               rd_hit = 1'b1;
            end
         end
      end
   end

   assign rvalid_d = s_axi_rvalid ? !s_axi_rready : (s_axi_arready & s_axi_arvalid);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OK;
      end else begin
         s_axi_arready <= !rvalid_d;
         s_axi_rvalid <= rvalid_d;
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? RESP_OK : RESP_ERR;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_busy_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
      |trig |=> seq_busy_o)
      else $error("busy did not follow a trigger");
   a_abort_index: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == S_IDLE && |pend_q && sel_idx == IDX_ABORT) |=> st_q == S_IDLE ##1 !cmd_valid_o)
      else $error("aborted trigger issued a step");
   a_start_index: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == S_IDLE && |pend_q && sel_idx != IDX_ABORT)
      |=> st_q == S_EXEC && cur_q == $past(sel_idx))
      else $error("sequence did not start at its index");
   a_last_index: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_valid_o |-> last_q == $past(cur_q))
      else $error("last index not updated with step");
   a_detect_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (!ctl_q.sd_en && det_r && !pend_q[6]) |=> !pend_q[6])
      else $error("detect edge queued while disabled");
   a_edge_pend: assert property (@(posedge clk_i) disable iff (rst_i)
      jack_r or pin_f |=> pend_q[4] || pend_q[3])
      else $error("edge was not queued");
   a_done_empty: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_done_o |-> st_q == S_IDLE && pend_q == '0 && !seq_busy_o)
      else $error("done flagged with work left");
   a_exec_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == S_EXEC) |=> seq_busy_o ##1 seq_busy_o)
      else $error("busy low while a step runs");
endmodule // wsevt_top

// ### tb/tb.sv
// Self-checking bench for the sequencer event-trigger front end.
// Assumes the design package and the top module are compiled first.
`timescale 1ns/1ps
module tb;
   import wsevt_pkg::*;
   logic clk_i, rst_i;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic accessory_detect_i, general_pin_five_i, detect_i;
   logic clamp_o, seq_busy_o, seq_done_o, cmd_valid_o, busy_seen;
   wsevt_step_t cmd_o;
   logic [31:0] cmds[$];
   int stamps[$];
   int cyc, ndone, mismatches, n_checks, k;
   wsevt_top #(.UNIT_CYC_P(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .accessory_detect_i(accessory_detect_i), .general_pin_five_i(general_pin_five_i),
      .detect_i(detect_i), .clamp_o(clamp_o), .seq_busy_o(seq_busy_o), .seq_done_o(seq_done_o),
      .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o));
   // ----------------------------------------------------------------
   // Clock, monitors and helpers
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cmd_valid_o === 1'b1) begin
         cmds.push_back(cmd_o);
         stamps.push_back(cyc);
      end
      if (seq_done_o === 1'b1) ndone <= ndone + 1;
      if (seq_busy_o === 1'b1) busy_seen <= 1'b1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [31:0] stp(input logic [7:0] d, input logic [3:0] dl);
      wsevt_step_t s;
      s = '{width: 3'h7, addr: 13'h0123, delay: dl, lsb: 4'h4, data: d};
      return s;
   endfunction
   task automatic axi_wr(input logic [13:0] idx, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_i);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_i);
         t++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 100);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      if (t >= 100) mismatches++;
   endtask
   task automatic axi_rd(input logic [13:0] idx);
      int t;
      t = 0;
      @(posedge clk_i);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_i);
         t++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 100);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      if (t >= 100) mismatches++;
   endtask
   task automatic wait_done();
      int d0, t;
      d0 = ndone;
      t = 0;
      while (ndone == d0 && t < 3000) begin
         @(posedge clk_i);
         t++;
      end
      if (t >= 3000) mismatches++;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   initial begin
      #(8 * 60000);
      mismatches++;
      finish_test();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      {accessory_detect_i, general_pin_five_i, detect_i, busy_seen} = '0;
      {cyc, ndone, mismatches, n_checks} = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (k = 0; k < NSRC; k++) begin
         axi_rd(IDX_TRIG[k]);
         chk(rd, 32'h000001FF);
      end
      axi_rd(IDX_STATUS);
      chk(rd, 32'h00000000);
      axi_rd(14'h0050);
      chk({30'h0, resp}, {30'h0, RESP_ERR});
      axi_wr(14'h0050, 32'h00000001);
      chk({30'h0, resp}, {30'h0, RESP_ERR});
      axi_wr(IDX_STATUS, 32'h000003FF);
      chk({30'h0, resp}, {30'h0, RESP_OK});
      axi_rd(IDX_STATUS);
      chk(rd, 32'h00000000);
      axi_wr({MEM_PAGE, 8'h10}, stp(8'hA5, DLY_END));
      axi_wr({MEM_PAGE, 8'h20}, stp(8'h11, DLY_MIN));
      axi_wr({MEM_PAGE, 8'h21}, stp(8'h22, DLY_END));
      axi_wr({MEM_PAGE, 8'h30}, stp(8'h33, DLY_END));
      axi_wr({MEM_PAGE, 8'h40}, stp(8'h44, DLY_END));
      axi_wr({MEM_PAGE, 8'h41}, stp(8'h55, DLY_END));
      axi_wr(IDX_JACK_RISE, 32'h10);
      axi_wr(IDX_PIN_RISE, 32'h20);
      axi_wr(IDX_PIN_FALL, 32'h40);
      axi_wr(IDX_CLAMP_RISE, 32'h30);
      axi_wr(IDX_DET_RISE, 32'h40);
      axi_wr(IDX_DET_FALL, 32'h41);
      axi_rd(IDX_JACK_RISE);
      chk(rd, 32'h00000010);
      // Jack rise runs one step; status is read while the step's delay runs
      accessory_detect_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      axi_rd(IDX_STATUS);
      chk(rd, 32'h00000210);
      wait_done();
      chk(cmds[0], stp(8'hA5, DLY_END));
      axi_rd(IDX_STATUS);
      chk(rd, 32'h00000010);
      // Jack fall left at the abort index: busy only, no step
      busy_seen <= 1'b0;
      accessory_detect_i <= 1'b0;
      repeat (600) @(posedge clk_i);
      chk(cmds.size(), 1);
      chk({31'h0, busy_seen}, 1);
      general_pin_five_i <= 1'b1;
      wait_done();
      chk(cmds[1], stp(8'h11, DLY_MIN));
      chk(cmds[2], stp(8'h22, DLY_END));
      chk(stamps[2] - stamps[1], STEP_CYC);
      general_pin_five_i <= 1'b0;
      wait_done();
      chk(cmds[3], stp(8'h44, DLY_END));
      // Clamp follows jack; jack and clamp rises both queue
      axi_wr(IDX_CTRL, 32'h2);
      k = ndone;
      accessory_detect_i <= 1'b1;
      repeat (3000) @(posedge clk_i);
      chk({31'h0, clamp_o}, 1);
      chk(cmds.size(), 6);
      chk(ndone - k, 1);
      chk(cmds[4], stp(8'hA5, DLY_END));
      chk(cmds[5], stp(8'h33, DLY_END));
      // Detect edges refused while disabled, taken once enabled
      detect_i <= 1'b1;
      repeat (600) @(posedge clk_i);
      detect_i <= 1'b0;
      repeat (600) @(posedge clk_i);
      chk(cmds.size(), 6);
      axi_wr(IDX_CTRL, 32'h3);
      detect_i <= 1'b1;
      wait_done();
      chk(cmds[6], stp(8'h44, DLY_END));
      detect_i <= 1'b0;
      wait_done();
      chk(cmds[7], stp(8'h55, DLY_END));
      // Reset while idle: fields return to abort, memory kept
      accessory_detect_i <= 1'b0;
      repeat (600) @(posedge clk_i);
      do_reset();
      axi_rd(IDX_JACK_RISE);
      chk(rd, 32'h000001FF);
      axi_wr(IDX_JACK_RISE, 32'h10);
      accessory_detect_i <= 1'b1;
      wait_done();
      chk(cmds[cmds.size() - 1], stp(8'hA5, DLY_END));
      // Mid-range delay waits unit time times (2^d - 1)
      axi_wr({MEM_PAGE, 8'h50}, stp(8'h66, 4'h2));
      axi_wr({MEM_PAGE, 8'h51}, stp(8'h77, DLY_END));
      axi_wr(IDX_JACK_FALL, 32'h50);
      accessory_detect_i <= 1'b0;
      wait_done();
      chk(cmds[cmds.size() - 1], stp(8'h77, DLY_END));
      chk(stamps[stamps.size() - 1] - stamps[stamps.size() - 2], 4 * 3);
      finish_test();
   end
endmodule // tb
